// *** nvmas_top.sv ***
// Purpose: command sequencer between the processor, the debug port and the nonvolatile arrays
// Assumes: AHB-Lite register slave, one requester at a time on the memory port
// Notes: the array itself sits outside and follows nv_start and nv_rd
// Summary of operation
// - signature area readable by both requesters, writes and erases refused
// - 32-byte user area read and written by software, kept through chip erase
// - debug port reads user area only unlocked, writes it even when locked
// - stored fuse image copied to configuration outputs at end of start-up
// - fuses readable by both, programmable only from the debug port, bytewise
// - flash starts at 0x0000 in code space and 0x8000 in data space
// - code-space writes are word writes, pointer bit 0 ignored
// - code-space reads return low byte for bit 0 clear, high byte otherwise
// - target address latched when a programming operation starts
// - one 32 KB data-space window, block chosen by the window select field
// - reads stall with wait states while a write or erase runs
// - byte per data store, word per code store, code space never reaches EEPROM
// - up to 32 flash pages per erase, same duration for any count
// - EEPROM erase up to 32 bytes, byte writes, combined erase-write
// - user area erased whole, written bytewise, page write when locked from debug
// - whole erases start on command write, other commands only arm a mode
// - key then command within four instructions, otherwise command ignored
// - write mode starts an operation for every store while it stays selected
// - page erase mode erases the addressed page, processor halted during erase
// - multi-page erase clears an aligned group, low page bits ignored
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module nvmas_top
    import nvmas_pkg::*;
#(
    parameter int FL_ERASE_CYCLES = nvmas_pkg::FL_ERASE_CYC,
    parameter int EE_ERASE_CYCLES = nvmas_pkg::EE_ERASE_CYC
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic instr_tick,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_code,
    input wire logic mem_dbg,
    input wire logic [2:0] mem_region,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic dev_locked,
    output logic mem_ready,
    output logic mem_err,
    output logic [7:0] mem_rdata,
    output logic cpu_halt,
    output logic nv_start,
    output logic nv_rd,
    output logic [3:0] nv_kind,
    output logic [2:0] nv_area,
    output logic [15:0] nv_addr,
    output logic [15:0] nv_wdata,
    output logic [5:0] nv_span,
    input wire logic [15:0] nv_rdata,
    input wire logic [31:0] fuse_image,
    output logic [31:0] fuse_cfg,
    output logic boot_done
);
    import nvmas_pkg::*;

    typedef struct packed {
        logic [6:0] cmd;
        logic [1:0] fmap;
        logic err_flag;
        logic d_wr;
        logic [7:0] d_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        nvmas_st_e st;
        logic boot_done;
        logic [31:0] fuse_cfg;
        logic mem_ready;
        logic mem_err;
        logic [7:0] mem_rdata;
        logic byte_hi;
        logic nv_start;
        logic nv_rd;
        logic [3:0] nv_kind;
        logic [2:0] nv_area;
        logic [15:0] nv_addr;
        logic [15:0] nv_wdata;
        logic [5:0] nv_span;
        logic cpu_halt;
    } nvmas_top_s;
    nvmas_top_s s, next_s;

    logic fl_busy;
    logic ee_busy;
    logic key_open;
    logic key_hit;
    logic cmd_take;
    logic fl_go;
    logic ee_go;
    logic [TMR_W-1:0] fl_load;
    logic [TMR_W-1:0] ee_load;
    logic [2:0] area;
    logic [15:0] faddr;
    logic acc_err;
    logic [3:0] kind;
    logic [15:0] op_addr;
    logic [5:0] span;
    logic on_flash;
    logic halt_go;

    // clear the low n address bits for a grouped erase
    function automatic logic [15:0] align_low(input logic [15:0] a, input logic [3:0] n);
        logic [15:0] m;
        m = 16'hffff << n;
        return a & m;
    endfunction : align_low

    // group size exponent of a multi-unit erase command
    function automatic logic [3:0] group_bits(input logic [6:0] c, input logic [6:0] base);
        logic [6:0] d;
        d = c - base + 7'h1;
        return d[3:0];
    endfunction : group_bits

    // key register write opens the command window
    assign key_hit = s.d_wr && s.d_addr == OFS_KEY && hwdata[7:0] == PROT_KEY;
    assign cmd_take = s.d_wr && s.d_addr == OFS_CMD && key_open;

    // flash address of the request: code space at zero, data space through the window
    always_comb
    begin
        if (mem_code)
            faddr = mem_addr;
        else
            faddr = {s.fmap[0], mem_addr[14:0]};
        if (mem_code || mem_addr[15])
            area = AREA_FLASH;
        else
            area = mem_region;
    end

    // decide the array operation for a store in the armed mode
    always_comb
    begin
        acc_err = 1'b0;
        kind = OP_WR_BYTE;
        op_addr = (area == AREA_FLASH) ? faddr : mem_addr;
        span = 6'h1;
        on_flash = 1'b1;
        if (mem_code && mem_region != AREA_FLASH)
            acc_err = 1'b1;
        else if (!mem_we)
            acc_err = mem_dbg && dev_locked && area == AREA_USER;
        else
        begin
            unique case (area)
                AREA_FLASH:
                begin
                    if (s.cmd == CMD_FLASH_WRITE_MODE)
                    begin
                        kind = mem_code ? OP_WR_WORD : OP_WR_BYTE;
                        if (mem_code)
                            op_addr = {faddr[15:1], 1'b0};
                    end
                    else if (s.cmd == CMD_FLASH_PAGE_ERASE_MODE)
                    begin
                        kind = OP_ERASE;
                        op_addr = align_low(faddr, 4'(PAGE_LSB));
                    end
                    else if (s.cmd >= CMD_FLMPER2 && s.cmd <= CMD_FLMPER32)
                    begin
                        kind = OP_ERASE;
                        op_addr = align_low(faddr, 4'(PAGE_LSB)) & ~(16'h1ff << group_bits(s.cmd, CMD_FLMPER2));
                        span = 6'h1 << group_bits(s.cmd, CMD_FLMPER2);
                    end
                    else
                        acc_err = 1'b1;
                end
                AREA_USER:
                begin
                    if (s.cmd == CMD_FLASH_WRITE_MODE)
                        kind = (mem_dbg && dev_locked) ? OP_WR_PAGE : OP_WR_BYTE;
                    else if (s.cmd == CMD_FLASH_PAGE_ERASE_MODE || (s.cmd >= CMD_FLMPER2 && s.cmd <= CMD_FLMPER32))
                    begin
                        kind = OP_ERASE;
                        op_addr = 16'h0000;
                        span = USER_BYTES;
                    end
                    else
                        acc_err = 1'b1;
                end
                AREA_EEPROM, AREA_FUSE:
                begin
                    on_flash = 1'b0;
                    acc_err = (area == AREA_FUSE) && !mem_dbg;
                    if (s.cmd == CMD_EEWR)
                        kind = OP_WR_BYTE;
                    else if (s.cmd == CMD_EEERWR)
                        kind = OP_ERASE_WR;
                    else if (s.cmd == CMD_EEBER)
                        kind = OP_ERASE;
                    else if (s.cmd >= CMD_EEMBER2 && s.cmd <= CMD_EEMBER32 && area == AREA_EEPROM)
                    begin
                        kind = OP_ERASE;
                        op_addr = align_low(mem_addr, group_bits(s.cmd, CMD_EEMBER2));
                        span = 6'h1 << group_bits(s.cmd, CMD_EEMBER2);
                    end
                    else
                        acc_err = 1'b1;
                end
                default:
                    acc_err = 1'b1;
            endcase
        end
    end

    // sequencer, register slave and operation launch
    always_comb
    begin
        next_s = s;
        fl_go = 1'b0;
        ee_go = 1'b0;
        halt_go = 1'b0;
        fl_load = TMR_W'(FL_WRITE_CYC);
        ee_load = TMR_W'(EE_WRITE_CYC);
        next_s.nv_start = 1'b0;
        next_s.nv_rd = 1'b0;
        next_s.mem_ready = 1'b0;
        next_s.mem_err = 1'b0;
        next_s.hreadyout = 1'b1;
        // address phase: capture and prefetch read data
        next_s.d_wr = 1'b0;
        if (hsel && htrans[1] && hready)
        begin
            next_s.d_wr = hwrite;
            next_s.d_addr = haddr[7:0];
            if (!hwrite)
            begin
                unique case (haddr[7:0])
                    OFS_CMD: next_s.hrdata = {25'h0, s.cmd};
                    OFS_MAP: next_s.hrdata = 32'({s.fmap, 4'h0});
                    OFS_STATUS: next_s.hrdata = {28'h0, key_open, s.err_flag, ee_busy, fl_busy};
                    default: next_s.hrdata = 32'h0;
                endcase
            end
        end
        // data phase writes
        if (s.d_wr && s.d_addr == OFS_MAP)
            next_s.fmap = hwdata[MAP_LSB+1:MAP_LSB];
        if (cmd_take)
        begin
            next_s.cmd = hwdata[6:0];
            next_s.err_flag = 1'b0;
            if (fl_busy || ee_busy)
                next_s.err_flag = 1'b1;
            else if (hwdata[6:0] == CMD_WHOLE_CHIP_ERASE_CMD)
            begin
                fl_go = 1'b1;
                ee_go = 1'b1;
                fl_load = TMR_W'(FL_ERASE_CYCLES);
                ee_load = TMR_W'(EE_ERASE_CYCLES);
                halt_go = 1'b1;
                next_s.nv_start = 1'b1;
                next_s.nv_kind = OP_CHIP;
                next_s.nv_area = AREA_FLASH;
                next_s.nv_span = 6'h0;
            end
            else if (hwdata[6:0] == CMD_WHOLE_EEPROM_ERASE_CMD)
            begin
                ee_go = 1'b1;
                ee_load = TMR_W'(EE_ERASE_CYCLES);
                halt_go = 1'b1;
                next_s.nv_start = 1'b1;
                next_s.nv_kind = OP_EE_ALL;
                next_s.nv_area = AREA_EEPROM;
                next_s.nv_span = 6'h0;
            end
        end
        // memory access sequencer
        unique case (s.st)
            NVMAS_BOOT:
            begin
                next_s.fuse_cfg = fuse_image;
                next_s.boot_done = 1'b1;
                next_s.st = NVMAS_IDLE;
            end
            NVMAS_IDLE:
            begin
                if (mem_req && !fl_busy && !ee_busy && !cmd_take)
                begin
                    if (acc_err)
                    begin
                        next_s.mem_ready = 1'b1;
                        next_s.mem_err = 1'b1;
                        next_s.err_flag = 1'b1;
                        next_s.st = NVMAS_ACK;
                    end
                    else if (!mem_we)
                    begin
                        next_s.nv_rd = 1'b1;
                        next_s.nv_area = area;
                        next_s.nv_addr = (area == AREA_FLASH) ? faddr : mem_addr;
                        next_s.byte_hi = mem_addr[0];
                        next_s.st = NVMAS_READ;
                    end
                    else
                    begin
                        next_s.nv_start = 1'b1;
                        next_s.nv_kind = kind;
                        next_s.nv_area = area;
                        next_s.nv_addr = op_addr;
                        next_s.nv_wdata = mem_wdata;
                        next_s.nv_span = span;
                        fl_go = on_flash;
                        ee_go = !on_flash;
                        if (kind == OP_ERASE && on_flash)
                        begin
                            fl_load = TMR_W'(FL_ERASE_CYCLES);
                            halt_go = 1'b1;
                        end
                        next_s.mem_ready = 1'b1;
                        next_s.st = NVMAS_ACK;
                    end
                end
            end
            NVMAS_READ:
            begin
                next_s.mem_rdata = s.byte_hi ? nv_rdata[15:8] : nv_rdata[7:0];
                next_s.mem_ready = 1'b1;
                next_s.st = NVMAS_ACK;
            end
            NVMAS_ACK:
                next_s.st = NVMAS_IDLE;
        endcase
        // processor halt follows erase busy time
        next_s.cpu_halt = halt_go || (s.cpu_halt && (fl_busy || ee_busy));
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
            s.cmd <= CMD_RST;
            s.fmap <= MAP_RST;
            s.hreadyout <= 1'b1;
            s.st <= NVMAS_BOOT;
        end
        else if (ce)
            s <= next_s;
    end

    // flash and EEPROM busy timers
    nvmas_timer u_fl_tmr (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .start(fl_go),
        .load(fl_load),
        .busy(fl_busy)
    );
    nvmas_timer u_ee_tmr (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .start(ee_go),
        .load(ee_load),
        .busy(ee_busy)
    );

    // protection key window
    nvmas_keywin u_key (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .key_hit(key_hit),
        .instr_tick(instr_tick),
        .consume(cmd_take),
        .open_win(key_open)
    );

    // outputs straight from the state register, hresp tied low
    assign hreadyout = s.hreadyout;
    assign hrdata = s.hrdata;
    assign hresp = 1'b0;
    assign mem_ready = s.mem_ready;
    assign mem_err = s.mem_err;
    assign mem_rdata = s.mem_rdata;
    assign cpu_halt = s.cpu_halt;
    assign nv_start = s.nv_start;
    assign nv_rd = s.nv_rd;
    assign nv_kind = s.nv_kind;
    assign nv_area = s.nv_area;
    assign nv_addr = s.nv_addr;
    assign nv_wdata = s.nv_wdata;
    assign nv_span = s.nv_span;
    assign fuse_cfg = s.fuse_cfg;
    assign boot_done = s.boot_done;
endmodule : nvmas_top
`default_nettype wire

// *** nvmas_pkg.sv ***
// Purpose: shared constants for the nonvolatile memory access and command sequencer
// Assumes: 25 MHz system clock, 64 KB flash in 512-byte pages
// Notes: command codes and operation timings are free choices of this block
package nvmas_pkg;
    // register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_MAP = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_KEY = 8'h0c;
    // field positions
    localparam int MAP_LSB = 4;
    localparam int ST_FLASH_BUSY_FLAG = 0;
    localparam int ST_EEPROM_BUSY_FLAG = 1;
    localparam int ST_ERR = 2;
    localparam int ST_KEYOPEN = 3;
    // reset values
    localparam logic [6:0] CMD_RST = 7'h00;
    localparam logic [1:0] MAP_RST = 2'h0;
    // protection key, value arbitrary
    localparam logic [7:0] PROT_KEY = 8'h5a;
    localparam logic [2:0] KEY_INSTR = 3'h4;
    // command codes
    localparam logic [6:0] CMD_NO_OPERATION_CMD = 7'h00;
    localparam logic [6:0] CMD_FLASH_WRITE_MODE = 7'h02;
    localparam logic [6:0] CMD_FLASH_PAGE_ERASE_MODE = 7'h08;
    localparam logic [6:0] CMD_FLMPER2 = 7'h09;
    localparam logic [6:0] CMD_FLMPER32 = 7'h0d;
    localparam logic [6:0] CMD_EEWR = 7'h12;
    localparam logic [6:0] CMD_EEERWR = 7'h13;
    localparam logic [6:0] CMD_EEBER = 7'h18;
    localparam logic [6:0] CMD_EEMBER2 = 7'h19;
    localparam logic [6:0] CMD_EEMBER32 = 7'h1d;
    localparam logic [6:0] CMD_WHOLE_CHIP_ERASE_CMD = 7'h20;
    localparam logic [6:0] CMD_WHOLE_EEPROM_ERASE_CMD = 7'h30;
    localparam logic [6:0] CMD_CLEAR_COMMAND_CMD = 7'h7f;
    // target areas
    localparam logic [2:0] AREA_FLASH = 3'h0;
    localparam logic [2:0] AREA_EEPROM = 3'h1;
    localparam logic [2:0] AREA_USER = 3'h2;
    localparam logic [2:0] AREA_SIG = 3'h3;
    localparam logic [2:0] AREA_FUSE = 3'h4;
    // operation kinds sent to the array
    localparam logic [3:0] OP_WR_BYTE = 4'h1;
    localparam logic [3:0] OP_WR_WORD = 4'h2;
    localparam logic [3:0] OP_ERASE = 4'h3;
    localparam logic [3:0] OP_ERASE_WR = 4'h4;
    localparam logic [3:0] OP_WR_PAGE = 4'h5;
    localparam logic [3:0] OP_CHIP = 4'h6;
    localparam logic [3:0] OP_EE_ALL = 4'h7;
    // geometry
    localparam int PAGE_LSB = 9;
    localparam logic [5:0] USER_BYTES = 6'h20;
    // timing
    localparam int CLK_MHZ = 25;
    localparam int FL_WRITE_NS = 70000;
    localparam int FL_ERASE_NS = 10000000;
    localparam int EE_WRITE_NS = 110000;
    localparam int EE_ERASE_NS = 4000000;
    localparam int FL_WRITE_CYC = (FL_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int FL_ERASE_CYC = (FL_ERASE_NS * CLK_MHZ + 999) / 1000;
    localparam int EE_WRITE_CYC = (EE_WRITE_NS * CLK_MHZ + 999) / 1000;
    localparam int EE_ERASE_CYC = (EE_ERASE_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 20;
    // sequencer states
    typedef enum logic [1:0] {NVMAS_BOOT, NVMAS_IDLE, NVMAS_READ, NVMAS_ACK} nvmas_st_e;
endpackage : nvmas_pkg

// *** nvmas_timer.sv ***
// Purpose: busy timer for one array, loaded with a cycle count on start
// Assumes: start is a one-cycle pulse from the same clock
// Notes: busy is high from the edge after start for load cycles
`timescale 1ns/100ps
`default_nettype none
module nvmas_timer
    import nvmas_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic start,
    input wire logic [nvmas_pkg::TMR_W-1:0] load,
    output logic busy
);
    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic busy;
    } nvmas_tmr_s;
    nvmas_tmr_s s, next_s;

    // count down, restart wins over the running count
    always_comb
    begin
        next_s = s;
        if (start)
        begin
            next_s.cnt = load;
            next_s.busy = 1'b1;
        end
        else if (s.busy)
        begin
            next_s.cnt = s.cnt - 1'b1;
            next_s.busy = (s.cnt != 1);
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    assign busy = s.busy;
endmodule : nvmas_timer
`default_nettype wire

// *** nvmas_keywin.sv ***
// Purpose: protection key window, open for a few instructions after the key
// Assumes: instr_tick pulses once per retired instruction
// Notes: a command write consumes the window
`timescale 1ns/100ps
`default_nettype none
module nvmas_keywin
    import nvmas_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic key_hit,
    input wire logic instr_tick,
    input wire logic consume,
    output logic open_win
);
    typedef struct packed {
        logic [2:0] left;
    } nvmas_key_s;
    nvmas_key_s s, next_s;

    // reload on key, count instructions down, close on use
    always_comb
    begin
        next_s = s;
        if (key_hit)
            next_s.left = KEY_INSTR;
        else if (consume)
            next_s.left = 3'h0;
        else if (instr_tick && s.left != 3'h0)
            next_s.left = s.left - 3'h1;
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    assign open_win = (s.left != 3'h0);
endmodule : nvmas_keywin
`default_nettype wire

// *** nvmas_checker.sv ***
// Purpose: port checker for nvmas_top
// Assumes: ce held high
// Notes: bound to the top at the foot
`timescale 1ns/100ps
`default_nettype none
module nvmas_checker
    import nvmas_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic mem_dbg,
    input wire logic mem_ready,
    input wire logic mem_err,
    input wire logic cpu_halt,
    input wire logic nv_start,
    input wire logic nv_rd,
    input wire logic [3:0] nv_kind,
    input wire logic [2:0] nv_area,
    input wire logic [15:0] nv_addr,
    input wire logic [5:0] nv_span,
    input wire logic [31:0] fuse_image,
    input wire logic [31:0] fuse_cfg,
    input wire logic boot_done
);
    // flash erase launched this cycle
    wire logic fl_er = nv_start && nv_kind == OP_ERASE && nv_area == AREA_FLASH;
    default clocking dc @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // refusals, reads, array starts
    a_err_ready: assert property (mem_err |-> mem_ready) else $error("lone error");
    a_rd_answer: assert property (nv_rd |=> mem_ready) else $error("read lost");
    a_halt_no_rd: assert property (cpu_halt |-> !nv_rd) else $error("read in erase");
    a_sig_no_prog: assert property (nv_start |-> nv_area != AREA_SIG) else $error("sig write");
    a_fuse_dbg: assert property (nv_start && nv_area == AREA_FUSE |-> mem_dbg) else $error("cpu fuse");
    a_erase_align: assert property (fl_er |-> ((nv_addr >> 9) & 16'(nv_span - 6'h1)) == 16'h0)
        else $error("unaligned erase");
    a_erase_halt: assert property (fl_er |-> ##[0:1] cpu_halt) else $error("no halt");
    a_halt_hold: assert property ($rose(cpu_halt) |-> cpu_halt [*8]) else $error("short halt");
    a_fuse_copy: assert property ($rose(boot_done) |-> fuse_cfg == fuse_image) else $error("fuse copy");
    // main scenarios reached
    c_chip: cover property (nv_start && nv_kind == OP_CHIP);
    c_err: cover property (mem_err);
    c_read: cover property (nv_rd);
endmodule : nvmas_checker
bind nvmas_top nvmas_checker chk_u (.hclk, .hresetn, .mem_dbg, .mem_ready, .mem_err, .cpu_halt, .nv_start,
    .nv_rd, .nv_kind, .nv_area, .nv_addr, .nv_span, .fuse_image, .fuse_cfg, .boot_done);
`default_nettype wire

// *** nvmas_array_model.sv ***
// Purpose: array stand-in answering reads
// Assumes: nv_rd is a one-cycle pulse
// Notes: low byte is addr[8:1], high its inverse
`timescale 1ns/100ps
`default_nettype none
module nvmas_array_model
(
    input wire logic hclk,
    input wire logic nv_rd,
    input wire logic [15:0] nv_addr,
    output logic [15:0] nv_rdata
);
    // word loaded mid-pulse, toggling otherwise
    always_ff @(negedge hclk)
    begin
        nv_rdata <= nv_rd ? {~nv_addr[8:1], nv_addr[8:1]} : ~nv_rdata;
    end
endmodule : nvmas_array_model
`default_nettype wire

// *** test_nvmas_top.sv ***
// Purpose: self-checking bench for nvmas_top
// Assumes: ce high, hready fed from hreadyout
// Notes: erase counts cut to 20 and 15 cycles
`timescale 1ns/100ps
`default_nettype none
module test_nvmas_top;
    import nvmas_pkg::*;
    logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, instr_tick = '0, dev_locked = '0;
    logic mem_req = '0, mem_we = '0, mem_code = '0, mem_dbg = '0;
    logic hreadyout, hresp, mem_ready, mem_err, cpu_halt, nv_start, nv_rd, boot_done;
    logic [1:0] htrans = '0;
    logic [2:0] mem_region = '0, nv_area;
    logic [3:0] nv_kind;
    logic [5:0] nv_span;
    logic [7:0] mem_rdata;
    logic [15:0] mem_addr = '0, mem_wdata = '0, nv_addr, nv_wdata, nv_rdata;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, fuse_cfg, rd;
    int err_count = 0, check_count = 0, cyc = 0, n;
    localparam logic [31:0] FUSE = 32'ha5c3_0f96;
    always #20 hclk = ~hclk;
    nvmas_top #(.FL_ERASE_CYCLES(20), .EE_ERASE_CYCLES(15)) dut_u (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .instr_tick,
        .mem_req, .mem_we, .mem_code, .mem_dbg, .mem_region, .mem_addr, .mem_wdata, .dev_locked, .mem_ready,
        .mem_err, .mem_rdata, .cpu_halt, .nv_start, .nv_rd, .nv_kind, .nv_area, .nv_addr, .nv_wdata, .nv_span,
        .nv_rdata, .fuse_image(FUSE), .fuse_cfg, .boot_done);
    nvmas_array_model model_u (.hclk, .nv_rd, .nv_addr, .nv_rdata);
    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", nm, e, g);
            err_count++;
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // one single AHB transfer, read data left in rd
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    // wait idle, unlock, write the command
    task automatic cmd(input logic [6:0] c);
        do ahb(1'b0, OFS_STATUS, 32'h0); while (rd[1:0] !== 2'h0);
        ahb(1'b1, OFS_KEY, {24'h0, PROT_KEY});
        ahb(1'b1, OFS_CMD, {25'h0, c});
    endtask : cmd
    // one memory request held until ready, wait length in n
    task automatic mem(input logic w, c, dg, input logic [2:0] rg, input logic [15:0] a);
        int t;
        @(posedge hclk);
        t = cyc;
        mem_req <= 1'b1;
        mem_we <= w;
        mem_code <= c;
        mem_dbg <= dg;
        mem_region <= rg;
        mem_addr <= a;
        mem_wdata <= ~a;
        do @(posedge hclk); while (mem_ready !== 1'b1);
        n = cyc - t;
        mem_req <= 1'b0;
    endtask : mem
    task automatic t_key;
        ahb(1'b1, OFS_CMD, 32'h2);
        ahb(1'b0, OFS_CMD, 32'h0);
        chk("no key", 7'h0d, rd);
        ahb(1'b1, OFS_KEY, {24'h0, PROT_KEY});
        instr_tick <= 1'b1;
        repeat (5) @(posedge hclk);
        instr_tick <= 1'b0;
        ahb(1'b1, OFS_CMD, 32'h2);
        ahb(1'b0, OFS_CMD, 32'h0);
        chk("late key", 7'h0d, rd);
        cmd(CMD_FLASH_WRITE_MODE);
        ahb(1'b0, OFS_CMD, 32'h0);
        chk("cmd kept", CMD_FLASH_WRITE_MODE, rd);
    endtask : t_key
    task automatic t_flash_write_mode;
        mem(1'b1, 1'b1, 1'b0, AREA_FLASH, 16'h4123);
        chk("word", OP_WR_WORD, nv_kind);
        chk("wd", 16'hbedc, nv_wdata);
        chk("word addr", 15'h2091, nv_addr[15:1]);
        mem(1'b0, 1'b1, 1'b0, AREA_FLASH, 16'h0055);
        chk("stall", 1'b1, n > 1700);
        chk("high", 8'hd5, mem_rdata);
        mem(1'b0, 1'b1, 1'b0, AREA_FLASH, 16'h0054);
        chk("low", 8'h2a, mem_rdata);
        ahb(1'b1, OFS_MAP, 32'h00);
        mem(1'b1, 1'b0, 1'b0, AREA_FLASH, 16'hc125);
        chk("byte", OP_WR_BYTE, nv_kind);
        chk("window", 16'h4125, nv_addr);
    endtask : t_flash_write_mode
    task automatic t_refuse;
        dev_locked <= 1'b1;
        mem(1'b1, 1'b0, 1'b0, AREA_SIG, 16'h0004);
        chk("sig wr", 1'b1, mem_err);
        mem(1'b1, 1'b1, 1'b0, AREA_EEPROM, 16'h0004);
        chk("code ee", 1'b1, mem_err);
        mem(1'b0, 1'b0, 1'b1, AREA_USER, 16'h0004);
        chk("user rd", 1'b1, mem_err);
        mem(1'b1, 1'b0, 1'b0, AREA_FUSE, 16'h0004);
        chk("fuse wr", 1'b1, mem_err);
        mem(1'b1, 1'b0, 1'b1, AREA_USER, 16'h0004);
        chk("user wr", OP_WR_PAGE, nv_kind);
        dev_locked <= 1'b0;
    endtask : t_refuse
    task automatic t_erase;
        int t;
        for (int j = 0; j < 6; j++)
        begin
            cmd(j == 0 ? CMD_FLASH_PAGE_ERASE_MODE : 7'(CMD_FLMPER2 + j - 1));
            mem(1'b1, 1'b1, 1'b0, AREA_FLASH, 16'h7e55);
            chk("span", 6'h1 << j, nv_span);
            chk("page", 16'h7e55 & (16'hffff << (9 + j)), nv_addr);
            mem(1'b0, 1'b1, 1'b0, AREA_FLASH, 16'h0000);
            if (j == 0)
                t = n;
            chk("erase time", t, n);
        end
    endtask : t_erase
    task automatic t_whole;
        for (int j = 0; j < 2; j++)
        begin
            cmd(j == 0 ? CMD_WHOLE_CHIP_ERASE_CMD : CMD_WHOLE_EEPROM_ERASE_CMD);
            repeat (1) @(posedge hclk);
            chk("whole start", 1'b1, nv_start);
            chk("whole kind", j == 0 ? OP_CHIP : OP_EE_ALL, nv_kind);
        end
        cmd(CMD_NO_OPERATION_CMD);
    endtask : t_whole
    // hang guard
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_count++;
            end_sim();
        end
    end
    // main sequence
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("fuse", FUSE, fuse_cfg);
        t_erase();
        t_key();
        t_flash_write_mode();
        t_refuse();
        t_whole();
        end_sim();
    end
endmodule : test_nvmas_top
`default_nettype wire
